// [inc/dlc_pkg.sv]
// Purpose: Constants and carrier types of the data link control register
// Assumes: One 8-bit control register on a synchronous host port
// Notes: Bit positions follow the register layout, MSB first
package dlc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0] ADDR_DATALINK_CTRL = 8'h00;
	localparam logic [7:0] DATALINK_CTRL_RST = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Field positions of datalink_ctrl
	localparam int unsigned POS_RX_CODE_DETECTOR_RESET = 7;
	localparam int unsigned POS_RX_LINK_CTRL_RESET = 6;
	localparam int unsigned POS_TX_IDLE_PATTERN_SELECT = 5;
	localparam int unsigned POS_TX_LINK_CTRL_RESET = 4;
	localparam int unsigned POS_TX_ABORT_TRIGGER = 3;
	localparam int unsigned POS_TX_END_OF_MESSAGE = 2;
	localparam int unsigned POS_TX_ZERO_INSERT_DEFEAT = 1;
	localparam int unsigned POS_TX_CRC_DEFEAT = 0;

	////////////////////////////////////////////////////////////////////////////
	// Transmit fill bytes
	localparam logic [7:0] BYTE_FLAG = 8'h7e;
	localparam logic [7:0] BYTE_IDLE_ONES = 8'hff;
	localparam logic [7:0] BYTE_ABORT = 8'hfe;

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dlc_bus_s;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] rdata;
		logic rx_code_rst;
		logic rx_link_rst;
		logic tx_link_rst;
		logic tx_flush;
		logic abort_pend;
		logic [7:0] fill;
		logic zero_ins_en;
		logic crc_en;
	} dlc_state_s;

endpackage

// [hw/dlc_datalink_ctrl.sv]
// Purpose: Data link control register with edge-triggered resets and abort
// Assumes: Host port strobes come from logic on I_MCLK, no synchroniser
// Notes: All outputs are flip-flops; I_CE low freezes every state bit
`timescale 1ns/100ps
`default_nettype none

// Function
// RQ1 - Rising code-detector bit resets receive code detector
// RQ2 - Rising receive link bit resets receive controller
// RQ3 - Rising transmit link bit resets transmit paths
// RQ4 - Idle select: zero gives 7Eh, one FFh
// RQ5 - Rising abort flushes FIFO, sends one FEh
// RQ6 - Zero-insert defeat bit disables zero insertion
// RQ7 - CRC defeat bit suppresses transmit CRC
module dlc_datalink_ctrl (
	// Clock, reset, enable
	input wire logic I_MCLK,
	input wire logic I_RESET,
	input wire logic I_CE,
	// Host register port
	input wire dlc_pkg::dlc_bus_s I_BUS,
	output logic [7:0] O_RDATA,
	// Transmit serializer handshake
	input wire logic I_TX_BYTE_TAKEN,
	// Reset pulses to the controllers
	output logic O_RX_CODE_RST,
	output logic O_RX_LINK_RST,
	output logic O_TX_LINK_RST,
	output logic O_TX_CODE_RST,
	// Transmit path control
	output logic O_TX_FLUSH,
	output logic [7:0] O_TX_FILL_BYTE,
	output logic O_TX_ZERO_INSERT_EN,
	output logic O_TX_CRC_EN,
	output logic O_TX_EOM
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Reset and abort fire on a 0 to 1 change only, so a held bit is inert
	function automatic logic rise(input logic [7:0] old_v, input logic [7:0] new_v,
		input int unsigned pos);
		rise = new_v[pos] & ~old_v[pos];
	endfunction

	// Only one register is mapped; both strobes share this decode
	function automatic logic hit_ctrl(input logic [7:0] a);
		hit_ctrl = (a == dlc_pkg::ADDR_DATALINK_CTRL);
	endfunction

	function automatic logic [7:0] idle_byte(input logic [7:0] c);
		idle_byte = c[dlc_pkg::POS_TX_IDLE_PATTERN_SELECT] ?
			dlc_pkg::BYTE_IDLE_ONES : dlc_pkg::BYTE_FLAG;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	localparam dlc_pkg::dlc_state_s STATE_RST = '{
		ctrl: dlc_pkg::DATALINK_CTRL_RST,
		rdata: dlc_pkg::RDATA_UNMAPPED,
		rx_code_rst: 1'b0,
		rx_link_rst: 1'b0,
		tx_link_rst: 1'b0,
		tx_flush: 1'b0,
		abort_pend: 1'b0,
		fill: dlc_pkg::BYTE_FLAG,
		zero_ins_en: 1'b1,
		crc_en: 1'b1
	};

	dlc_pkg::dlc_state_s state_r;
	dlc_pkg::dlc_state_s state_nxt;
	logic wr_hit;

	assign wr_hit = I_BUS.wr && hit_ctrl(I_BUS.addr);

	always_comb begin
		state_nxt = state_r;
		state_nxt.rx_code_rst = 1'b0;
		state_nxt.rx_link_rst = 1'b0;
		state_nxt.tx_link_rst = 1'b0;
		state_nxt.tx_flush = 1'b0;
		// Byte handed out, abort byte is spent
		if (I_TX_BYTE_TAKEN) begin
			state_nxt.abort_pend = 1'b0; // RQ5
		end
		if (wr_hit) begin
			state_nxt.ctrl = I_BUS.wdata;
			state_nxt.rx_code_rst = rise(state_r.ctrl, I_BUS.wdata,
				dlc_pkg::POS_RX_CODE_DETECTOR_RESET); // RQ1
			state_nxt.rx_link_rst = rise(state_r.ctrl, I_BUS.wdata,
				dlc_pkg::POS_RX_LINK_CTRL_RESET); // RQ2
			state_nxt.tx_link_rst = rise(state_r.ctrl, I_BUS.wdata,
				dlc_pkg::POS_TX_LINK_CTRL_RESET); // RQ3
			// New abort wins over a byte taken in the same cycle
			if (rise(state_r.ctrl, I_BUS.wdata, dlc_pkg::POS_TX_ABORT_TRIGGER)) begin
				state_nxt.tx_flush = 1'b1; // RQ5
				state_nxt.abort_pend = 1'b1; // RQ5
			end
		end
		// Abort byte first, then flag or idle until new data arrives
		state_nxt.fill = state_nxt.abort_pend ? dlc_pkg::BYTE_ABORT :
			idle_byte(state_nxt.ctrl); // RQ4 RQ5
		// Enables kept as own flops so the outputs need no inverter
		state_nxt.zero_ins_en = ~state_nxt.ctrl[dlc_pkg::POS_TX_ZERO_INSERT_DEFEAT]; // RQ6
		state_nxt.crc_en = ~state_nxt.ctrl[dlc_pkg::POS_TX_CRC_DEFEAT]; // RQ7
		if (I_BUS.rd) begin
			if (hit_ctrl(I_BUS.addr)) begin
				state_nxt.rdata = state_r.ctrl;
			end else begin
				state_nxt.rdata = dlc_pkg::RDATA_UNMAPPED;
			end
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			state_r <= STATE_RST;
		end else if (I_CE) begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign O_RDATA = state_r.rdata;
	assign O_RX_CODE_RST = state_r.rx_code_rst;
	assign O_RX_LINK_RST = state_r.rx_link_rst;
	// One pulse serves both transmit controllers
	assign O_TX_LINK_RST = state_r.tx_link_rst; // RQ3
	assign O_TX_CODE_RST = state_r.tx_link_rst; // RQ3
	assign O_TX_FLUSH = state_r.tx_flush;
	assign O_TX_FILL_BYTE = state_r.fill;
	assign O_TX_ZERO_INSERT_EN = state_r.zero_ins_en; // RQ6
	assign O_TX_CRC_EN = state_r.crc_en; // RQ7
	// Cleared only by a host write or reset, kept here as a plain stored bit
	assign O_TX_EOM = state_r.ctrl[dlc_pkg::POS_TX_END_OF_MESSAGE];

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RESET);

	sequence abort_edge_s;
		I_CE && wr_hit && I_BUS.wdata[dlc_pkg::POS_TX_ABORT_TRIGGER] &&
			!state_r.ctrl[dlc_pkg::POS_TX_ABORT_TRIGGER];
	endsequence

	sequence abort_out_s;
		O_TX_FLUSH && (O_TX_FILL_BYTE == dlc_pkg::BYTE_ABORT);
	endsequence

	code_rst_edge_a: assert property ( // RQ1
		(I_CE && wr_hit) |=> (O_RX_CODE_RST ==
			($past(I_BUS.wdata[dlc_pkg::POS_RX_CODE_DETECTOR_RESET]) &&
			!$past(state_r.ctrl[dlc_pkg::POS_RX_CODE_DETECTOR_RESET]))))
		else $error("code detector reset pulse wrong");

	link_rst_held_a: assert property ( // RQ2
		(I_CE && !wr_hit) |=> !O_RX_LINK_RST)
		else $error("receive link reset without rising write");

	rx_link_edge_a: assert property ( // RQ2
		(I_CE && wr_hit && I_BUS.wdata[dlc_pkg::POS_RX_LINK_CTRL_RESET] &&
			!state_r.ctrl[dlc_pkg::POS_RX_LINK_CTRL_RESET]) |=>
			(O_RX_LINK_RST ##1 (!$past(I_CE) || !O_RX_LINK_RST)))
		else $error("receive link reset pulse missing or stretched");

	tx_rst_both_a: assert property ( // RQ3
		(I_CE && wr_hit && I_BUS.wdata[dlc_pkg::POS_TX_LINK_CTRL_RESET] &&
			!state_r.ctrl[dlc_pkg::POS_TX_LINK_CTRL_RESET]) |=> (O_TX_LINK_RST && O_TX_CODE_RST))
		else $error("transmit resets not both pulsed");

	idle_pattern_a: assert property ( // RQ4
		!state_r.abort_pend |-> (O_TX_FILL_BYTE ==
			(state_r.ctrl[dlc_pkg::POS_TX_IDLE_PATTERN_SELECT] ?
			dlc_pkg::BYTE_IDLE_ONES : dlc_pkg::BYTE_FLAG)))
		else $error("idle fill byte wrong");

	abort_byte_a: assert property ( // RQ5
		abort_edge_s |=> abort_out_s)
		else $error("abort did not flush and send abort byte");

	abort_done_a: assert property ( // RQ5
		(I_CE && state_r.abort_pend && I_TX_BYTE_TAKEN && !wr_hit) |=>
			(O_TX_FILL_BYTE != dlc_pkg::BYTE_ABORT))
		else $error("abort byte sent more than once");

	zero_insert_a: assert property ( // RQ6
		(I_CE && wr_hit) |=> (O_TX_ZERO_INSERT_EN ==
			!$past(I_BUS.wdata[dlc_pkg::POS_TX_ZERO_INSERT_DEFEAT])))
		else $error("zero insertion enable wrong");

	crc_enable_a: assert property ( // RQ7
		(I_CE && wr_hit) |=> (O_TX_CRC_EN == !$past(I_BUS.wdata[dlc_pkg::POS_TX_CRC_DEFEAT])))
		else $error("crc enable wrong");

	// Quiet when no write is taken: a held bit never fires again
	code_rst_quiet_a: assert property ( // RQ1
		(I_CE && !wr_hit) |=> !O_RX_CODE_RST)
		else $error("code detector reset without rising write");

	tx_rst_quiet_a: assert property ( // RQ3
		(I_CE && !wr_hit) |=> (!O_TX_LINK_RST && !O_TX_CODE_RST))
		else $error("transmit reset without rising write");

	flush_quiet_a: assert property ( // RQ5
		(I_CE && !wr_hit) |=> !O_TX_FLUSH)
		else $error("flush without rising abort write");

	abort_hold_a: assert property ( // RQ5
		(I_CE && state_r.abort_pend && !I_TX_BYTE_TAKEN) |=>
			(O_TX_FILL_BYTE == dlc_pkg::BYTE_ABORT))
		else $error("abort byte dropped before it was taken");

	levels_held_a: assert property ( // RQ6 RQ7
		(I_CE && !wr_hit) |=> ($stable(O_TX_ZERO_INSERT_EN) && $stable(O_TX_CRC_EN)))
		else $error("stuffing or crc enable changed without a write");

endmodule

`default_nettype wire

// [bench/dlc_host_model.sv]
// Purpose: Host processor model on the register port
// Assumes: Strobes change on the falling edge of the clock
// Notes: Released address and data show inverted values, never stale ones
`timescale 1ns/100ps
`default_nettype none
module dlc_host_model (
	// Clock
	input wire logic i_clk,
	// Register port
	output var dlc_pkg::dlc_bus_s o_bus,
	input wire logic [7:0] i_rdata
);
	initial o_bus = '0;

	////////////////////////////////////////////////////////////////////////////
	// One access; returns at the edge where the answer is settled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge i_clk) o_bus <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge i_clk) o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		q = i_rdata;
	endtask
endmodule
`default_nettype wire

// [bench/test_datalink_hdlc_control.sv]
// Purpose: Self-checking bench of the data link control register
// Assumes: Clock enable tied high, host model drives the port
// Notes: Pulses are sampled half a cycle after the taking edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module test_datalink_hdlc_control;
	logic i_mclk = 1'b0;
	logic i_reset = 1'b1;
	logic i_taken = 1'b0;
	dlc_pkg::dlc_bus_s bus;
	logic [7:0] rdata, fill, q;
	logic rxc, rxl, txl, txc, flush, zins, crc, eom;
	int bad_count = 0;
	int samples_checked = 0;
	logic [7:0] wv [4] = '{8'h80, 8'h40, 8'h10, 8'h08};
	logic [4:0] pv [4] = '{5'h10, 5'h08, 5'h06, 5'h01};
	always #5 i_mclk = ~i_mclk;
	dlc_datalink_ctrl dlc_datalink_ctrl_inst (.I_MCLK(i_mclk), .I_RESET(i_reset), .I_CE(1'b1),
		.I_BUS(bus), .O_RDATA(rdata), .I_TX_BYTE_TAKEN(i_taken), .O_RX_CODE_RST(rxc),
		.O_RX_LINK_RST(rxl), .O_TX_LINK_RST(txl), .O_TX_CODE_RST(txc), .O_TX_FLUSH(flush),
		.O_TX_FILL_BYTE(fill), .O_TX_ZERO_INSERT_EN(zins), .O_TX_CRC_EN(crc), .O_TX_EOM(eom));
	dlc_host_model dlc_host_model_inst (.i_clk(i_mclk), .o_bus(bus), .i_rdata(rdata));

	////////////////////////////////////////////////////////////////////////////
	// Access tasks and closing
	task automatic wr(input logic [7:0] d);
		dlc_host_model_inst.xfer(1'b1, dlc_pkg::ADDR_DATALINK_CTRL, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		dlc_host_model_inst.xfer(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask
	task automatic finish_test();
		$display("checked %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Tests
	initial begin
		repeat (16) @(negedge i_mclk);
		i_reset = 1'b0;
		`CHK({fill, zins, crc, eom}, {dlc_pkg::BYTE_FLAG, 3'b110})
		rd(dlc_pkg::ADDR_DATALINK_CTRL, dlc_pkg::DATALINK_CTRL_RST);
		// Second set without a clear must stay silent
		for (int i = 0; i < 4; i++) begin
			wr(8'h00);
			wr(wv[i]);
			`CHK({rxc, rxl, txl, txc, flush}, pv[i])
			wr(wv[i]);
			`CHK({rxc, rxl, txl, txc, flush}, 5'h00)
		end
		`CHK(fill, dlc_pkg::BYTE_ABORT)
		@(negedge i_mclk) i_taken = 1'b1;
		@(negedge i_mclk) i_taken = 1'b0;
		`CHK(fill, dlc_pkg::BYTE_FLAG)
		wr(8'h27);
		`CHK({fill, zins, crc, eom}, {dlc_pkg::BYTE_IDLE_ONES, 3'b001})
		rd(dlc_pkg::ADDR_DATALINK_CTRL, 8'h27);
		rd(8'h01, dlc_pkg::RDATA_UNMAPPED);
		wr(8'h00);
		`CHK({fill, zins, crc, eom}, {dlc_pkg::BYTE_FLAG, 3'b110})
		finish_test();
	end

	// Tests need about 0.5 us; a hang ends well before the run grows long
	initial begin
		#20us;
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
